// ===== src/fpb_pkg.sv
// Constants, register map and timing figures for the PWM1 source binding block.
package fpb_pkg;

    // Clock and time base.
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
    localparam int unsigned RAMP_STEP_US    = 1000;
    localparam int unsigned RAMP_STEP_CYC   = RAMP_STEP_US * CLK_PER_US;
    localparam int unsigned PWM_SLOT_US     = 100;
    localparam int unsigned PWM_SLOT_CYC    = PWM_SLOT_US * CLK_PER_US;
    localparam int unsigned PWM_STEPS       = 15;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_INTERVAL    = 8'hC7;
    localparam logic [7:0]  IDX_BINDING     = 8'hC8;
    localparam logic [7:0]  IDX_OVERRIDE    = 8'hC9;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hE0;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'hE1;
    localparam logic [11:0] ADDR_INTERVAL   = {2'b00, IDX_INTERVAL, 2'b00};
    localparam logic [11:0] ADDR_BINDING    = {2'b00, IDX_BINDING, 2'b00};
    localparam logic [11:0] ADDR_OVERRIDE   = {2'b00, IDX_OVERRIDE, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK   = {2'b00, IDX_IRQ_MASK, 2'b00};

    // Reset values.
    localparam logic [7:0]  RST_INTERVAL    = 8'h11;
    localparam logic [7:0]  RST_BINDING     = 8'h0F;
    localparam logic [7:0]  RST_OVERRIDE    = 8'h00;
    localparam logic [2:0]  RST_IRQ         = 3'h0;

    // Field positions of the interval register.
    localparam int unsigned CPU1_INTERVAL_LSB = 0;
    localparam int unsigned CPU2_INTERVAL_LSB = 4;

    // Field positions of the binding register.
    localparam int unsigned BIND_ZONE_ONE          = 0;
    localparam int unsigned BIND_CPU1_THROTTLE     = 4;
    localparam int unsigned BIND_CPU2_THROTTLE     = 5;
    localparam int unsigned BIND_REGULATOR_HOT_ONE = 6;

    // Field positions of the override register.
    localparam int unsigned MANUAL_DUTY_ENABLE   = 0;
    localparam int unsigned PWM_POLARITY_INVERT  = 1;
    localparam int unsigned THROTTLE_LOCK_ENABLE = 2;
    localparam int unsigned LOCK_FLAG_BIT        = 3;
    localparam int unsigned MANUAL_DUTY_LSB      = 4;

    // Interrupt status bits.
    localparam int unsigned IRQ_CPU1_WINDOW = 0;
    localparam int unsigned IRQ_CPU2_WINDOW = 1;
    localparam int unsigned IRQ_LOCK        = 2;

    // Monitoring windows in milliseconds for codes 0 to 9; higher codes are reserved.
    localparam int unsigned NUM_WINDOW_CODES = 10;
    localparam int unsigned WINDOW_MS [0:9] = '{730, 1460, 2900, 5800, 11700,
                                                23300, 46600, 93200, 186000, 372000};

    // Zone lookup: duty rises one step per four degrees above the base.
    localparam logic [7:0]  ZONE_BASE_TEMP  = 8'h28;
    localparam int unsigned ZONE_STEP_SHIFT = 2;
    localparam logic [3:0]  DUTY_FULL       = 4'hF;

endpackage : fpb_pkg

// ===== src/fpb_pwm1_binding.sv
// PWM1 source binding, throttle monitoring windows, override and lock, with APB registers.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module fpb_pwm1_binding #(
    parameter int unsigned WINDOW_CLK_PER_MS = fpb_pkg::CLK_PER_MS,
    parameter int unsigned RAMP_STEP_CYCLES  = fpb_pkg::RAMP_STEP_CYC
) (
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        CPU1_THROTTLE_N_I,
    input  wire logic        CPU2_THROTTLE_N_I,
    input  wire logic        REGULATOR_HOT_ONE_N_I,
    input  wire logic        REGULATOR_HOT_TWO_N_I,
    input  wire logic [7:0]  ZONE1_TEMP_I,
    input  wire logic [7:0]  ZONE2_TEMP_I,
    input  wire logic [7:0]  ZONE3_TEMP_I,
    input  wire logic [7:0]  ZONE4_TEMP_I,
    output logic      [1:0]  BOUND_THROTTLE_EVENT_STATUS_O,
    output logic             PWM1_O,
    output logic             IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Lookup from zone temperature to a 16-step duty code.
    function automatic logic [3:0] zone_lookup(input logic [7:0] temp);
        logic [7:0] above;
        above = 8'h00;
        if (temp < fpb_pkg::ZONE_BASE_TEMP) begin
            return 4'h0;
        end
        above = (temp - fpb_pkg::ZONE_BASE_TEMP) >> fpb_pkg::ZONE_STEP_SHIFT;
        if (above > 8'(fpb_pkg::DUTY_FULL)) begin
            return fpb_pkg::DUTY_FULL;
        end
        return above[3:0];
    endfunction

    function automatic logic [3:0] max_duty(input logic [3:0] a, input logic [3:0] b);
        return (a > b) ? a : b;
    endfunction

    // Last cycle count of a window; zero marks a reserved code.
    function automatic logic [31:0] window_last(input logic [3:0] code);
        longint unsigned cycles;
        cycles = 0;
        if (32'(code) >= fpb_pkg::NUM_WINDOW_CODES) begin
            return 32'h0000_0000;
        end
        cycles = longint'(fpb_pkg::WINDOW_MS[code]) * longint'(WINDOW_CLK_PER_MS);
        return 32'(cycles - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [7:0]  interval_reg;
    logic [7:0]  binding_reg;
    logic [7:0]  override_reg;
    logic        lock_flag_reg;
    logic [2:0]  irq_status_reg;
    logic [2:0]  irq_mask_reg;
    logic [31:0] prdata_reg;
    logic [31:0] win_cnt_reg [0:1];
    logic [1:0]  seen_reg;
    logic [1:0]  bound_status_reg;
    logic [1:0]  window_end;
    logic [31:0] ramp_tick_cnt_reg;
    logic        ramp_tick;
    logic [3:0]  ramp_reg [0:3];
    logic [3:0]  ramp_src;
    logic [1:0]  throttle_on;
    logic [3:0]  zone_duty [0:3];
    logic [3:0]  auto_duty;
    logic [3:0]  duty_used;
    logic        lock_event;
    logic [15:0] slot_cnt_reg;
    logic [3:0]  step_cnt_reg;
    logic        pwm_reg;
    logic        addr_hit;
    logic        wr_en;
    logic        rd_setup;
    logic [31:0] rd_data;
    logic [2:0]  irq_set;

    assign throttle_on = {~CPU2_THROTTLE_N_I, ~CPU1_THROTTLE_N_I};
    assign ramp_src    = {~REGULATOR_HOT_TWO_N_I, ~REGULATOR_HOT_ONE_N_I, throttle_on};

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: no wait states, unmapped addresses answer with an error.

    always_comb begin
        addr_hit = 1'b0;
        rd_data  = 32'h0000_0000;
        if (PADDR_I == fpb_pkg::ADDR_INTERVAL) begin
            addr_hit = 1'b1;
            rd_data  = {24'h00_0000, interval_reg};
        end else if (PADDR_I == fpb_pkg::ADDR_BINDING) begin
            addr_hit = 1'b1;
            rd_data  = {24'h00_0000, binding_reg};
        end else if (PADDR_I == fpb_pkg::ADDR_OVERRIDE) begin
            addr_hit = 1'b1;
            rd_data  = {24'h00_0000, duty_used, lock_flag_reg, override_reg[2:0]};
        end else if (PADDR_I == fpb_pkg::ADDR_IRQ_STATUS) begin
            addr_hit = 1'b1;
            rd_data  = {29'h0000_0000, irq_status_reg};
        end else if (PADDR_I == fpb_pkg::ADDR_IRQ_MASK) begin
            addr_hit = 1'b1;
            rd_data  = {29'h0000_0000, irq_mask_reg};
        end
    end

    // Ready is tied high, so every access phase lasts one cycle and a write lands
    // at the edge that ends it.
    assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I & addr_hit;
    assign rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;
    assign PRDATA_O  = prdata_reg;

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            interval_reg <= fpb_pkg::RST_INTERVAL;
            binding_reg  <= fpb_pkg::RST_BINDING;
            override_reg <= fpb_pkg::RST_OVERRIDE;
            irq_mask_reg <= fpb_pkg::RST_IRQ;
        end else if (wr_en) begin
            if (PADDR_I == fpb_pkg::ADDR_INTERVAL) begin
                interval_reg <= PWDATA_I[7:0];
            end else if (PADDR_I == fpb_pkg::ADDR_BINDING) begin
                binding_reg <= PWDATA_I[7:0];
            end else if (PADDR_I == fpb_pkg::ADDR_OVERRIDE) begin
                override_reg <= PWDATA_I[7:0];
            end else if (PADDR_I == fpb_pkg::ADDR_IRQ_MASK) begin
                irq_mask_reg <= PWDATA_I[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Throttle monitoring windows, one per processor input.

    // Changing a code in mid-window may end the running window at once with a
    // partial result, which is why codes should only change while the system sleeps.
    for (genvar c = 0; c < 2; c++) begin : g_window
        logic [31:0] last;
        assign last = window_last(interval_reg[4*c +: 4]);
        assign window_end[c] = (last != 32'h0000_0000) && (win_cnt_reg[c] >= last);

        // A reserved code parks the window counter and reports nothing.
        always_ff @(posedge CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                win_cnt_reg[c]      <= 32'h0000_0000;
                seen_reg[c]         <= 1'b0;
                bound_status_reg[c] <= 1'b0;
            end else if (last == 32'h0000_0000) begin
                win_cnt_reg[c] <= 32'h0000_0000;
                seen_reg[c]    <= 1'b0;
            end else if (window_end[c]) begin
                win_cnt_reg[c]      <= 32'h0000_0000;
                seen_reg[c]         <= 1'b0;
                bound_status_reg[c] <= seen_reg[c] | throttle_on[c];
            end else begin
                win_cnt_reg[c] <= win_cnt_reg[c] + 32'h0000_0001;
                seen_reg[c]    <= seen_reg[c] | throttle_on[c];
            end
        end
    end

    assign BOUND_THROTTLE_EVENT_STATUS_O = bound_status_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Ramp sources: throttle and regulator hot inputs.

    assign ramp_tick = (ramp_tick_cnt_reg == 32'(RAMP_STEP_CYCLES - 1));

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ramp_tick_cnt_reg <= 32'h0000_0000;
        end else if (ramp_tick) begin
            ramp_tick_cnt_reg <= 32'h0000_0000;
        end else begin
            ramp_tick_cnt_reg <= ramp_tick_cnt_reg + 32'h0000_0001;
        end
    end

    // A bound, asserted input ramps up; otherwise its request ramps down.
    for (genvar r = 0; r < 4; r++) begin : g_ramp
        logic up;
        assign up = ramp_src[r] & binding_reg[fpb_pkg::BIND_CPU1_THROTTLE + r];
        always_ff @(posedge CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                ramp_reg[r] <= 4'h0;
            end else if (ramp_tick) begin
                if (up && ramp_reg[r] != fpb_pkg::DUTY_FULL) begin
                    ramp_reg[r] <= ramp_reg[r] + 4'h1;
                end else if (!up && ramp_reg[r] != 4'h0) begin
                    ramp_reg[r] <= ramp_reg[r] - 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Duty selection.

    always_comb begin
        zone_duty[0] = zone_lookup(ZONE1_TEMP_I);
        zone_duty[1] = zone_lookup(ZONE2_TEMP_I);
        zone_duty[2] = zone_lookup(ZONE3_TEMP_I);
        zone_duty[3] = zone_lookup(ZONE4_TEMP_I);
    end

    // An unbound ramp still counts while it decays, so unbinding a source lowers
    // the duty gradually rather than at once.
    always_comb begin
        auto_duty = 4'h0;
        for (int z = 0; z < 4; z++) begin
            if (binding_reg[fpb_pkg::BIND_ZONE_ONE + z]) begin
                auto_duty = max_duty(auto_duty, zone_duty[z]);
            end
            auto_duty = max_duty(auto_duty, ramp_reg[z]);
        end
    end

    // Manual duty is one more request; a larger automatic request still wins.
    always_comb begin
        duty_used = auto_duty;
        if (override_reg[fpb_pkg::MANUAL_DUTY_ENABLE]) begin
            duty_used = max_duty(auto_duty, override_reg[7:fpb_pkg::MANUAL_DUTY_LSB]);
        end
        if (lock_flag_reg) begin
            duty_used = fpb_pkg::DUTY_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Full speed lock.

    assign lock_event = override_reg[fpb_pkg::THROTTLE_LOCK_ENABLE]
                      & |(throttle_on & binding_reg[fpb_pkg::BIND_CPU2_THROTTLE:
                                                    fpb_pkg::BIND_CPU1_THROTTLE]);

    // Software may only clear the flag; a new event in the same cycle wins.
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lock_flag_reg <= 1'b0;
        end else if (lock_event) begin
            lock_flag_reg <= 1'b1;
        end else if (wr_en && PADDR_I == fpb_pkg::ADDR_OVERRIDE
                     && !PWDATA_I[fpb_pkg::LOCK_FLAG_BIT]) begin
            lock_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status, write one to clear, set wins over clear.

    assign irq_set[fpb_pkg::IRQ_CPU1_WINDOW] = window_end[0] & (seen_reg[0] | throttle_on[0]);
    assign irq_set[fpb_pkg::IRQ_CPU2_WINDOW] = window_end[1] & (seen_reg[1] | throttle_on[1]);
    assign irq_set[fpb_pkg::IRQ_LOCK]        = lock_event & ~lock_flag_reg;

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            irq_status_reg <= fpb_pkg::RST_IRQ;
        end else if (wr_en && PADDR_I == fpb_pkg::ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~PWDATA_I[2:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    assign IRQ_O = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // PWM1 waveform: fifteen slots per period, code 15 is continuously on.

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            slot_cnt_reg <= 16'h0000;
            step_cnt_reg <= 4'h0;
        end else if (slot_cnt_reg == 16'(fpb_pkg::PWM_SLOT_CYC - 1)) begin
            slot_cnt_reg <= 16'h0000;
            if (step_cnt_reg == 4'(fpb_pkg::PWM_STEPS - 1)) begin
                step_cnt_reg <= 4'h0;
            end else begin
                step_cnt_reg <= step_cnt_reg + 4'h1;
            end
        end else begin
            slot_cnt_reg <= slot_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= (step_cnt_reg < duty_used) ^ override_reg[fpb_pkg::PWM_POLARITY_INVERT];
        end
    end

    assign PWM1_O = pwm_reg;

endmodule // fpb_pwm1_binding

`default_nettype wire

// ===== bench/fpb_fan_model.sv
// Cooling fan model that counts the cycles in which its PWM drive is high.
`timescale 1ns/1ps
`default_nettype none
module fpb_fan_model (
    input  wire logic        clk,
    input  wire logic        pwm,
    input  wire logic        clear,
    output logic      [15:0] high_cycles
);
    always_ff @(posedge clk) begin
        if (clear) high_cycles <= 16'h0000;
        else if (pwm) high_cycles <= high_cycles + 16'h0001;
    end
endmodule // fpb_fan_model
`default_nettype wire

// ===== bench/fpb_checker_properties.sv
// Concurrent checks on the APB, interrupt and PWM ports of the PWM1 binding block.
`timescale 1ns/1ps
`default_nettype none
module fpb_checker (
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        PWM1_O,
    input wire logic        IRQ_O
);
    logic [7:0] int_reg;
    logic [7:0] bnd_reg;
    logic [7:0] ovr_reg;
    wire logic acc = PSEL_I && PENABLE_I;
    wire logic rd = acc && !PWRITE_I;
    wire logic full = ovr_reg[0] && !ovr_reg[1] && ovr_reg[7:4] == 4'hF;
    wire logic mapped = PADDR_I inside {fpb_pkg::ADDR_INTERVAL, fpb_pkg::ADDR_BINDING,
        fpb_pkg::ADDR_OVERRIDE, fpb_pkg::ADDR_IRQ_STATUS, fpb_pkg::ADDR_IRQ_MASK};
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            int_reg <= fpb_pkg::RST_INTERVAL;
            bnd_reg <= fpb_pkg::RST_BINDING;
            ovr_reg <= fpb_pkg::RST_OVERRIDE;
        end else if (acc && PWRITE_I) begin
            if (PADDR_I == fpb_pkg::ADDR_INTERVAL) int_reg <= PWDATA_I[7:0];
            if (PADDR_I == fpb_pkg::ADDR_BINDING) bnd_reg <= PWDATA_I[7:0];
            if (PADDR_I == fpb_pkg::ADDR_OVERRIDE) ovr_reg <= PWDATA_I[7:0];
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_ready_high: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("access phase without ready");
    a_err_unmapped: assert property (acc && !mapped
        |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0000_0000))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && mapped |-> !PSLVERR_O)
        else $error("mapped access refused");
    a_interval_readback: assert property (rd && PADDR_I == fpb_pkg::ADDR_INTERVAL
        |-> PRDATA_O == {24'h00_0000, int_reg})
        else $error("interval read differs from last write");
    a_binding_readback: assert property (rd && PADDR_I == fpb_pkg::ADDR_BINDING
        |-> PRDATA_O == {24'h00_0000, bnd_reg})
        else $error("binding read differs from last write");
    a_lock_full_read: assert property (rd && PADDR_I == fpb_pkg::ADDR_OVERRIDE && PRDATA_O[3]
        |-> PRDATA_O[7:4] == 4'hF)
        else $error("lock flag set without full duty");
    a_manual_floor: assert property (rd && PADDR_I == fpb_pkg::ADDR_OVERRIDE && ovr_reg[0]
        && ovr_reg == $past(ovr_reg, 3) |-> PRDATA_O[7:4] >= ovr_reg[7:4])
        else $error("duty read below manual value");
    a_irq_fall_write: assert property ($fell(IRQ_O) |-> $past(acc && PWRITE_I))
        else $error("interrupt dropped without a write");
    a_full_duty_high: assert property (full && $past(full, 3) |-> PWM1_O)
        else $error("full manual duty not high");
endmodule // fpb_checker
bind fpb_pwm1_binding fpb_checker u_checker (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PWM1_O(PWM1_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking testbench for the PWM1 source binding block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int WIN = 730;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pwm, irq;
    logic c1_n = 1, c2_n = 1, h1_n = 1, h2_n = 1, fan_clr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [7:0] z1 = 8'h00, z2 = 8'h00, z3 = 8'h00, z4 = 8'h00;
    logic [1:0] evt;
    logic [15:0] fan_cnt;
    logic e;
    int mismatches = 0, cmp_count = 0, n;
    logic [11:0] row_a [5] = '{fpb_pkg::ADDR_INTERVAL, fpb_pkg::ADDR_BINDING,
        fpb_pkg::ADDR_OVERRIDE, fpb_pkg::ADDR_IRQ_MASK, 12'h000};
    logic [7:0] row_w [5] = '{8'h93, 8'hC0, 8'hF1, 8'h07, 8'h55};
    logic [7:0] row_r [5] = '{8'h93, 8'hC0, 8'hF1, 8'h07, 8'h00};
    logic [7:0] rst_v [5] = '{fpb_pkg::RST_INTERVAL, fpb_pkg::RST_BINDING,
        fpb_pkg::RST_OVERRIDE, 8'h00, 8'h00};
    always #50 clk = ~clk;
    fpb_pwm1_binding #(.WINDOW_CLK_PER_MS(1), .RAMP_STEP_CYCLES(4)) u_dut (.CLK_I(clk),
        .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CPU1_THROTTLE_N_I(c1_n), .CPU2_THROTTLE_N_I(c2_n),
        .REGULATOR_HOT_ONE_N_I(h1_n), .REGULATOR_HOT_TWO_N_I(h2_n), .ZONE1_TEMP_I(z1),
        .ZONE2_TEMP_I(z2), .ZONE3_TEMP_I(z3), .ZONE4_TEMP_I(z4),
        .BOUND_THROTTLE_EVENT_STATUS_O(evt), .PWM1_O(pwm), .IRQ_O(irq));
    fpb_fan_model u_fan (.clk(clk), .pwm(pwm), .clear(fan_clr), .high_cycles(fan_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] x, input string m);
        repeat (4) @(posedge clk);
        apb(0, a, 8'h00);
        check(r, {24'h00_0000, x}, m);
    endtask
    task automatic fan_chk(input logic [15:0] x);
        fan_clr <= 1;
        @(posedge clk);
        fan_clr <= 0;
        repeat (15000) @(posedge clk);
        @(negedge clk);
        check({16'h0000, fan_cnt}, {16'h0000, x}, "fan high cycles");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100_000 * 100);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 5; i++) begin
            apb(1, row_a[i], row_w[i]);
            check({31'h0, e}, {31'h0, row_a[i] == 12'h000}, "write error");
            rchk(row_a[i], row_r[i], "row readback");
        end
        $display("test rows done");
        @(posedge clk) rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        for (int i = 0; i < 4; i++) rchk(row_a[i], rst_v[i], "reset value");
        rchk(fpb_pkg::ADDR_IRQ_STATUS, 8'h00, "reset status");
        $display("test reset done");
        z1 <= 8'h3C; z2 <= 8'h20; z3 <= 8'h44;
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h70, "zone max duty");
        apb(1, fpb_pkg::ADDR_BINDING, 8'h01);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h50, "zone one duty");
        $display("test zones done");
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'h31);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h51, "duty above manual");
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'hA1);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'hA1, "manual duty");
        fan_chk(16'd10000);
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'hA3);
        fan_chk(16'd5000);
        $display("test manual done");
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'h00);
        apb(1, fpb_pkg::ADDR_BINDING, 8'h40);
        h2_n <= 0;
        repeat (80) @(posedge clk);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h00, "unbound hot input");
        h1_n <= 0;
        repeat (80) @(posedge clk);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'hF0, "ramp up");
        h1_n <= 1; h2_n <= 1;
        repeat (80) @(posedge clk);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h00, "ramp down");
        $display("test ramps done");
        apb(1, fpb_pkg::ADDR_IRQ_MASK, 8'h01);
        apb(1, fpb_pkg::ADDR_INTERVAL, 8'h00);
        c1_n <= 0;
        repeat (10) @(posedge clk);
        c1_n <= 1;
        n = 0;
        while (evt[0] !== 1'b1 && n < 800) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n <= WIN + 1}, 32'h0000_0001, "window end");
        check({30'h0, evt}, 32'h0000_0001, "event status");
        @(negedge clk) check({31'h0, irq}, 32'h0000_0001, "irq raised");
        apb(1, fpb_pkg::ADDR_IRQ_MASK, 8'h00);
        @(negedge clk) check({31'h0, irq}, 32'h0000_0000, "irq masked");
        apb(1, fpb_pkg::ADDR_IRQ_STATUS, 8'h01);
        rchk(fpb_pkg::ADDR_IRQ_STATUS, 8'h00, "status cleared");
        apb(1, fpb_pkg::ADDR_INTERVAL, 8'hAA);
        c2_n <= 0;
        repeat (800) @(posedge clk);
        c2_n <= 1;
        rchk(fpb_pkg::ADDR_IRQ_STATUS, 8'h00, "reserved code quiet");
        check({30'h0, evt}, 32'h0000_0001, "reserved code holds");
        $display("test window done");
        apb(1, fpb_pkg::ADDR_BINDING, 8'h10);
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'h04);
        c1_n <= 0;
        repeat (5) @(posedge clk);
        c1_n <= 1;
        repeat (100) @(posedge clk);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'hFC, "lock held");
        apb(0, fpb_pkg::ADDR_IRQ_STATUS, 8'h00);
        check(r & 32'h0000_0004, 32'h0000_0004, "lock status");
        apb(1, fpb_pkg::ADDR_OVERRIDE, 8'h04);
        repeat (100) @(posedge clk);
        rchk(fpb_pkg::ADDR_OVERRIDE, 8'h04, "lock cleared");
        $display("test lock done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
